// ==== gpd_port_regs.sv ====
`timescale 1ns/10ps
// Function
// R1 - Reading any direction register returns all ones regardless of contents.
// R2 - Bit set or clear reads the byte, changes one bit, writes byte back.
// R3 - A cleared direction bit makes its pin an input, not driven.
// R4 - A set direction bit drives its pin from the output latch.
// R5 - Output latch and pin readback share one address per port.
// R6 - Software keeps a shadow copy of direction bytes and writes it whole.
// R7 - Data reads give pin level for inputs, latch value for outputs.
// R8 - Byte writes update all eight bits; pins follow on the next clock.
module gpd_port_regs
	import gpd_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                                  REF_CLK,
	input  wire logic                                  RST_N,
	input  wire logic                                  CE,
	// APB slave
	input  wire logic                                  PSEL,
	input  wire logic                                  PENABLE,
	input  wire logic                                  PWRITE,
	input  wire logic [17:0]                           PADDR,
	input  wire logic [31:0]                           PWDATA,
	output logic      [31:0]                           PRDATA,
	output logic                                       PREADY,
	output logic                                       PSLVERR,
	// Port pins
	input  wire logic [GPD_PORTS-1:0][GPD_WIDTH-1:0]   PIN_IN,
	output gpd_pins_t [GPD_PORTS-1:0]                  PORT_PINS
);

	// Bus decode
	gpd_sel_t    acc_sel;
	logic        aligned;
	logic        is_cmd;
	logic        is_sts;
	logic        mapped;
	logic        bus_ready;
	logic        bus_done;
	logic        bus_wr;
	logic        rd_fresh_q;

	// Per-port views and strobes
	logic [GPD_PORTS-1:0][GPD_WIDTH-1:0] rd_view;
	logic [GPD_PORTS-1:0]                dir_we;
	logic [GPD_PORTS-1:0]                latch_we;
	logic [GPD_PORTS-1:0][GPD_WIDTH-1:0] wbyte;

	// Bit engine
	gpd_bitcmd_t          cmd;
	gpd_sel_t             eng_tgt;
	logic                 eng_busy;
	logic                 eng_wr;
	logic [GPD_WIDTH-1:0] eng_rd_q;
	logic [GPD_WIDTH-1:0] eng_wr_q;
	logic [GPD_WIDTH-1:0] eng_rd_byte;

	// Status and read data
	logic                 err_q;
	logic                 err_set;
	logic                 err_clr;
	logic [31:0]          prdata_q;
	logic [31:0]          rd_word;
	logic [31:0]          sts_word;

	// Byte seen by a read of a port register; shared by the bus and the engine
	function automatic logic [GPD_WIDTH-1:0] port_read(
		input gpd_sel_t                            s,
		input logic [GPD_PORTS-1:0][GPD_WIDTH-1:0] view
	);
		logic [GPD_WIDTH-1:0] b;
		b = '0;
		if (s.hit) begin
			b = s.is_dir ? GPD_DIR_READ : view[s.slot]; // [R1] [R7]
		end
		return b;
	endfunction : port_read

	// Address decode; misaligned addresses are unmapped
	assign aligned = (PADDR[1:0] == 2'b00);
	assign acc_sel = gpd_decode(PADDR[17:2]);
	assign is_cmd  = aligned && (PADDR[17:2] == GPD_BITOP_IDX);
	assign is_sts  = aligned && (PADDR[17:2] == GPD_STATUS_IDX);
	assign mapped  = (aligned && acc_sel.hit) || is_cmd || is_sts;

	// Stall while a bit operation owns the registers, the clock is gated,
	// or a read has not yet captured its data in this transfer
	assign bus_ready = CE && !eng_busy && !(PSEL && PENABLE && !PWRITE && !rd_fresh_q);
	assign PREADY    = bus_ready;
	assign bus_done  = PSEL && PENABLE && bus_ready;
	assign bus_wr    = bus_done && PWRITE && mapped;
	assign PSLVERR   = PSEL && PENABLE && !mapped;

	// A single write strobe per register, from the bus or from the engine
	generate
		for (genvar p = 0; p < GPD_PORTS; p++) begin : g_port
			always_comb begin
				dir_we[p]   = 1'b0;
				latch_we[p] = 1'b0;
				wbyte[p]    = PWDATA[GPD_WIDTH-1:0];
				if (bus_wr && aligned && acc_sel.hit && acc_sel.slot == 3'(p)) begin
					dir_we[p]   = acc_sel.is_dir;
					latch_we[p] = !acc_sel.is_dir; // [R5]
				end else if (eng_wr && eng_tgt.hit && eng_tgt.slot == 3'(p)) begin
					dir_we[p]   = eng_tgt.is_dir; // [R2]
					latch_we[p] = !eng_tgt.is_dir;
					wbyte[p]    = eng_wr_q;
				end
			end

			gpd_port_bank u_bank (
				.clk      (REF_CLK),
				.rst_n    (RST_N),
				.ce       (CE),
				.dir_we   (dir_we[p]),
				.latch_we (latch_we[p]),
				.wdata    (wbyte[p]),
				.pin_in   (PIN_IN[p]),
				.pins     (PORT_PINS[p]),
				.rd_view  (rd_view[p])
			);
		end
	endgenerate

	// Command word becomes a one-cycle request to the engine
	always_comb begin
		cmd        = '0;
		cmd.go     = bus_wr && is_cmd;
		cmd.set    = PWDATA[GPD_CMD_SET_POS];
		cmd.bit_no = PWDATA[GPD_CMD_BIT_LSB +: 3];
		cmd.tgt    = gpd_decode(PWDATA[GPD_CMD_TGT_LSB +: 16]);
	end

	// The engine reads exactly what the bus would, so the readback
	// hazards of a direction byte are reproduced faithfully
	assign eng_rd_byte = port_read(eng_tgt, rd_view); // [R2]

	gpd_bit_engine u_engine (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.cmd     (cmd),
		.busy    (eng_busy),
		.tgt     (eng_tgt),
		.rd_byte (eng_rd_byte),
		.wr_en   (eng_wr),
		.rd_q    (eng_rd_q),
		.wr_q    (eng_wr_q)
	);

	// Error flag: a command aimed at no port register; a new error wins
	// over a clear arriving in the same cycle
	assign err_set = cmd.go && !cmd.tgt.hit;
	assign err_clr = bus_wr && is_sts && PWDATA[GPD_STS_ERR_POS];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			err_q <= 1'b0;
		end else if (CE) begin
			if (err_set) begin
				err_q <= 1'b1;
			end else if (err_clr) begin
				err_q <= 1'b0;
			end
		end
	end

	// Status word shows the engine's own state
	always_comb begin
		sts_word                           = '0;
		sts_word[GPD_STS_BUSY_POS]         = eng_busy;
		sts_word[GPD_STS_ERR_POS]          = err_q;
		sts_word[GPD_STS_RD_LSB +: 8]      = eng_rd_q;
		sts_word[GPD_STS_WR_LSB +: 8]      = eng_wr_q;
	end

	// Read multiplexer; narrow registers sit in the low byte
	always_comb begin
		rd_word = '0;
		if (aligned && acc_sel.hit) begin
			rd_word[GPD_WIDTH-1:0] = port_read(acc_sel, rd_view); // [R1] [R5] [R7]
		end else if (is_sts) begin
			rd_word = sts_word;
		end
	end

	// Read data is sampled every cycle of a pending read so that pin
	// levels are no older than one clock when the access completes
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prdata_q <= GPD_RDATA_RST;
		end else if (CE && PSEL && !PWRITE && !(PENABLE && bus_ready)) begin
			prdata_q <= rd_word;
		end
	end

	// A setup cycle spent with the clock gated captures nothing, so without
	// this flag the access could complete on a stale word from an older read
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_fresh_q <= 1'b0;
		end else if (CE) begin
			if (!PSEL || (PENABLE && bus_ready)) begin
				rd_fresh_q <= 1'b0; // Cleared at completion and while idle
			end else if (!PWRITE) begin
				rd_fresh_q <= 1'b1;
			end
		end
	end

	assign PRDATA = prdata_q;

	// Direction bytes always read as all ones
	chk_dir_readback: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R1]
		PSEL && PENABLE && PREADY && !PWRITE && aligned && acc_sel.hit && acc_sel.is_dir
		&& $past(PSEL) && $past(PADDR) == PADDR
		|-> PRDATA == 32'h0000_00FF)
		else $error("direction read not all ones");

	// Data address read shows latch for outputs and pins for inputs
	chk_shared_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R5] [R7]
		PSEL && !PENABLE && !PWRITE && CE && aligned && acc_sel.hit && !acc_sel.is_dir
		|=> prdata_q[GPD_WIDTH-1:0] == $past(rd_view[acc_sel.slot]))
		else $error("data address read mismatch");

	// A bit operation writes back two cycles after its request
	chk_rmw_seq: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R2]
		cmd.go && cmd.tgt.hit && CE && !eng_busy
		##1 CE [*2] |-> eng_wr)
		else $error("bit operation did not write back");

endmodule : gpd_port_regs

// ==== gpd_pkg.sv ====
package gpd_pkg;

	// Port group geometry
	localparam int GPD_PORTS = 8;
	localparam int GPD_WIDTH = 8;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [15:0] GPD_LATCH_IDX [GPD_PORTS] = '{
		16'hFFD4, 16'hFFD5, 16'hFFD6, 16'hFFD8,
		16'hFFD9, 16'hFFDA, 16'hFFDB, 16'hFFDC
	};
	localparam logic [15:0] GPD_DIR_IDX [GPD_PORTS] = '{
		16'hFFE4, 16'hFFE5, 16'hFFE6, 16'hFFE8,
		16'hFFE9, 16'hFFEA, 16'hFFEB, 16'hFFEC
	};
	localparam logic [15:0] GPD_BITOP_IDX  = 16'hFFF0;
	localparam logic [15:0] GPD_STATUS_IDX = 16'hFFF1;

	// Values after reset and the fixed readback of a direction register
	localparam logic [7:0]  GPD_DIR_RST    = 8'h00;
	localparam logic [7:0]  GPD_LATCH_RST  = 8'h00;
	localparam logic [7:0]  GPD_DIR_READ   = 8'hFF;
	localparam logic [31:0] GPD_RDATA_RST  = 32'h0000_0000;

	// Bit-operation command fields
	localparam int GPD_CMD_BIT_LSB = 0;
	localparam int GPD_CMD_SET_POS = 3;
	localparam int GPD_CMD_TGT_LSB = 16;

	// Status fields
	localparam int GPD_STS_BUSY_POS = 0;
	localparam int GPD_STS_ERR_POS  = 1;
	localparam int GPD_STS_RD_LSB   = 8;
	localparam int GPD_STS_WR_LSB   = 16;

	// Decoded register target
	typedef struct packed {
		logic       hit;
		logic       is_dir;
		logic [2:0] slot;
	} gpd_sel_t;

	// Pin drive of one port
	typedef struct packed {
		logic [GPD_WIDTH-1:0] lvl;
		logic [GPD_WIDTH-1:0] oe;
	} gpd_pins_t;

	// Bit-operation request
	typedef struct packed {
		logic       go;
		logic       set;
		logic [2:0] bit_no;
		gpd_sel_t   tgt;
	} gpd_bitcmd_t;

	// Map a register index onto a port slot
	function automatic gpd_sel_t gpd_decode(input logic [15:0] idx);
		gpd_sel_t s;
		s = '0;
		for (int i = 0; i < GPD_PORTS; i++) begin
			if (idx == GPD_LATCH_IDX[i] || idx == GPD_DIR_IDX[i]) begin
				s.hit    = 1'b1;
				s.is_dir = (idx == GPD_DIR_IDX[i]);
				s.slot   = 3'(i);
			end
		end
		return s;
	endfunction : gpd_decode

endpackage : gpd_pkg

// ==== gpd_port_bank.sv ====
`timescale 1ns/10ps
module gpd_port_bank
	import gpd_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// Byte writes
	input  wire logic                 dir_we,
	input  wire logic                 latch_we,
	input  wire logic [GPD_WIDTH-1:0] wdata,
	// Pins
	input  wire logic [GPD_WIDTH-1:0] pin_in,
	output gpd_pins_t                 pins,
	output logic      [GPD_WIDTH-1:0] rd_view
);

	logic [GPD_WIDTH-1:0] dir_q;
	logic [GPD_WIDTH-1:0] latch_q;

	// Direction byte, all eight bits in one write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= GPD_DIR_RST;
		end else if (ce && dir_we) begin
			dir_q <= wdata; // [R8]
		end
	end

	// Output latch byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= GPD_LATCH_RST;
		end else if (ce && latch_we) begin
			latch_q <= wdata; // [R8]
		end
	end

	// Pins come straight from flops; a cleared bit releases its pin
	assign pins.oe  = dir_q;   // [R3] [R4]
	assign pins.lvl = latch_q; // [R4]
	// Inputs show the pin, outputs the latch
	assign rd_view = (dir_q & latch_q) | (~dir_q & pin_in); // [R7]

	chk_dir_follows: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		ce && dir_we |=> pins.oe == $past(wdata))
		else $error("direction did not follow write");
	chk_input_release: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		ce && dir_we && wdata == 8'h00 |=> pins.oe == 8'h00 && rd_view == pin_in)
		else $error("cleared direction still drives");
	chk_output_drive: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
		ce && latch_we && !dir_we |=> (pins.lvl & pins.oe) == ($past(wdata) & pins.oe))
		else $error("output level not from latch");

endmodule : gpd_port_bank

// ==== gpd_bit_engine.sv ====
`timescale 1ns/10ps
module gpd_bit_engine
	import gpd_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// Request
	input  gpd_bitcmd_t               cmd,
	output logic                      busy,
	// Byte access to the port registers
	output gpd_sel_t                  tgt,
	input  wire logic [GPD_WIDTH-1:0] rd_byte,
	output logic                      wr_en,
	output logic      [GPD_WIDTH-1:0] rd_q,
	output logic      [GPD_WIDTH-1:0] wr_q
);

	typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_STORE} gpd_eng_t;

	gpd_eng_t    state_q;
	gpd_bitcmd_t cmd_q;
	logic [GPD_WIDTH-1:0] mask;

	assign mask  = 8'(1) << cmd_q.bit_no;
	assign tgt   = cmd_q.tgt;
	assign busy  = (state_q != ENG_IDLE);
	assign wr_en = (state_q == ENG_STORE);

	// Sequence: read whole byte, alter one bit, write whole byte back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ENG_IDLE;
		end else if (ce) begin
			unique case (state_q)
				ENG_IDLE:  if (cmd.go) state_q <= ENG_FETCH;
				ENG_FETCH: state_q <= ENG_STORE; // [R2]
				ENG_STORE: state_q <= ENG_IDLE;
				// The fourth code of the two-bit state is unused; recover to idle
				default:   state_q <= ENG_IDLE;
			endcase
		end
	end

	// Command capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= '0;
		end else if (ce && state_q == ENG_IDLE && cmd.go) begin
			cmd_q <= cmd;
		end
	end

	// Read image and modified byte; a direction target reads all ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= '0;
			wr_q <= '0;
		end else if (ce && state_q == ENG_FETCH) begin
			rd_q <= rd_byte;
			wr_q <= cmd_q.set ? (rd_byte | mask) : (rd_byte & ~mask); // [R2]
		end
	end

	chk_rmw_byte: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		wr_en |-> (wr_q & ~mask) == (rd_q & ~mask) && (|(wr_q & mask)) == cmd_q.set)
		else $error("bit operation altered other bits");

endmodule : gpd_bit_engine

// ==== gpd_pin_board.sv ====
`timescale 1ns/10ps
// Board side of the port pins: a driven pin loops the device level back,
// an undriven pin shows what the board puts on it
module gpd_pin_board
	import gpd_pkg::*;
(
	// From the device
	input  gpd_pins_t [GPD_PORTS-1:0]                 port_pins,
	// Levels the board drives on undriven pins
	input  wire logic [GPD_PORTS-1:0][GPD_WIDTH-1:0]  board_lvl,
	// Resolved pin levels
	output logic      [GPD_PORTS-1:0][GPD_WIDTH-1:0]  pin_in
);
	// Per-bit resolve, so a stale device level never leaks onto an input pin
	always_comb begin
		for (int i = 0; i < GPD_PORTS; i++) begin
			pin_in[i] = (port_pins[i].oe & port_pins[i].lvl) | (~port_pins[i].oe & board_lvl[i]);
		end
	end
endmodule : gpd_pin_board

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import gpd_pkg::*;
	// Bench signals
	logic                                ref_clk = 1'b0;
	logic                                rst_n;
	logic                                psel, penable, pwrite, pready, pslverr, err;
	logic                                ce;
	logic [17:0]                         paddr;
	logic [31:0]                         pwdata, prdata, rd;
	logic [GPD_PORTS-1:0][GPD_WIDTH-1:0] pin_in, board;
	gpd_pins_t [GPD_PORTS-1:0]           port_pins;
	int                                  fail_count, num_checks, cycles;

	always #5 ref_clk = ~ref_clk;

	// Clock enable stays high except in the freeze scenario
	gpd_port_regs uut (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
		.PORT_PINS(port_pins));
	gpd_pin_board brd (.port_pins(port_pins), .board_lvl(board), .pin_in(pin_in));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer; waits on pready, the hang guard bounds the wait
	task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Let the edge after a store land before looking at the pins
	task settle();
		@(posedge ref_clk);
		#1;
	endtask : settle

	task t_reset();
		check("oe after reset", port_pins[2].oe, GPD_DIR_RST);
		apb(1'b0, GPD_DIR_IDX[2], 32'h0);
		check("dir read", rd, 32'hFF);
	endtask : t_reset

	// Bit clear on a direction byte, then the shadow-copy repair
	task t_bit_clear_instr_dir();
		board[2] <= 8'h41;
		apb(1'b1, GPD_DIR_IDX[2], 32'h3F);
		apb(1'b1, GPD_LATCH_IDX[2], 32'h80);
		settle();
		check("oe 3F", port_pins[2].oe, 8'h3F);
		check("lvl 80", port_pins[2].lvl, 8'h80);
		apb(1'b0, GPD_LATCH_IDX[2], 32'h0);
		check("latch mix", rd, 32'h40);
		apb(1'b1, GPD_BITOP_IDX, {16'hFFE6, 16'h0000});
		settle(); // Let the store finish so the status shows the engine idle
		apb(1'b0, GPD_STATUS_IDX, 32'h0);
		check("bit_clear_instr status", rd, 32'h00FEFF00);
		settle();
		check("oe FE", port_pins[2].oe, 8'hFE);
		apb(1'b1, GPD_DIR_IDX[2], 32'h3E);
		settle();
		check("oe 3E", port_pins[2].oe, 8'h3E);
		apb(1'b0, GPD_LATCH_IDX[2], 32'h0);
		check("pin0 input", rd, 32'h41);
	endtask : t_bit_clear_instr_dir

	// Bit set on a latch picks up input pin levels as well
	task t_bit_set_instr_latch();
		apb(1'b1, GPD_BITOP_IDX, {16'hFFD6, 16'h0009});
		apb(1'b0, GPD_STATUS_IDX, 32'h0);
		// Setup cycle falls in the store cycle, so the busy bit is still seen
		check("bit_set_instr status", rd, 32'h00434101);
		settle();
		check("lvl 43", port_pins[2].lvl, 8'h43);
	endtask : t_bit_set_instr_latch

	task t_all_ports();
		logic [7:0] l;
		for (int i = 0; i < GPD_PORTS; i++) begin
			board[i] <= 8'hC3 ^ 8'(i);
			l = 8'h5A ^ 8'(i);
			apb(1'b1, GPD_DIR_IDX[i], 32'hAA);
			apb(1'b1, GPD_LATCH_IDX[i], {24'h0, l});
			settle();
			check("port oe", port_pins[i].oe, 8'hAA);
			check("port lvl", port_pins[i].lvl, l);
			apb(1'b0, GPD_DIR_IDX[i], 32'h0);
			check("port dir read", rd, 32'hFF);
			apb(1'b0, GPD_LATCH_IDX[i], 32'h0);
			check("port data read", rd, {24'h0, (8'hAA & l) | (8'h55 & board[i])});
		end
	endtask : t_all_ports

	// Clock gated across the setup cycle: the read must still return live data
	task t_freeze();
		ce <= 1'b0;
		fork
			apb(1'b0, GPD_LATCH_IDX[0], 32'h0);
			begin
				repeat (3) @(posedge ref_clk);
				check("ready gated", pready, 1'b0);
				ce <= 1'b1;
			end
		join
		check("gated read", rd, {24'h0, (8'hAA & 8'h5A) | (8'h55 & 8'hC3)});
	endtask : t_freeze

	task t_unmapped();
		apb(1'b0, 16'hFFD7, 32'h0);
		check("gap err", err, 1'b1);
		check("gap read", rd, 32'h0);
		apb(1'b1, 16'h0000, 32'hFF);
		check("low err", err, 1'b1);
	endtask : t_unmapped

	task end_of_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Hang guard, well above the roughly 160 cycles the scenarios need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		board = '0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_bit_clear_instr_dir();
		t_bit_set_instr_latch();
		t_all_ports();
		t_freeze();
		t_unmapped();
		end_of_test();
	end
endmodule : tb_top
